// ===== core/lcd_port_pkg.sv
// shared constants for the lcd host port: widths, instruction codes, frame timing
// assumes a single 100 MHz clock shared by both ends of the port
package lcd_port_pkg;

    // ------------------------------------------------------------------
    // bus widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int ADDR_W = 7;

    // ------------------------------------------------------------------
    // instruction decode: width select lives in the function set code
    // ------------------------------------------------------------------
    localparam logic [2:0] FUNC_SET_CODE = 3'h1;
    localparam int FUNC_SET_MSB = 7;
    localparam int FUNC_SET_LSB = 5;
    localparam int WIDTH_SEL_BIT = 4;
    localparam int BUSY_BIT = 7;
    localparam logic [DATA_W-1:0] IDLE_LINE = 8'hFF;
    localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;

    // ------------------------------------------------------------------
    // frame timing, oscillator derived from the system clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PERIOD_NS = 12500;
    localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int CLKS_PER_COM = 60;
    localparam int COMS_PER_FRAME = 18;
    localparam int DIV_W = 11;
    localparam int CNT_W = 6;
    localparam int COM_W = 5;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CLKS_PER_COM - 1);
    localparam logic [COM_W-1:0] COM_LAST = COM_W'(COMS_PER_FRAME - 1);

endpackage

// ===== core/lcd_port_if.sv
// the parallel host port between microprocessor end and display end
// assumes both ends run on the same clock; data lines idle high via pull-ups
`timescale 1ns/1ps
interface lcd_port_if;
    import lcd_port_pkg::*;

    logic accessStb;
    logic regSel;
    logic readNotWrite;
    logic [DATA_W-1:0] hostData;
    logic hostDataOe;
    logic [DATA_W-1:0] devData;
    logic devDataOe;
    logic [DATA_W-1:0] dataLine;

    // ------------------------------------------------------------------
    // wire resolution; pull-ups give all ones when nobody drives
    // ------------------------------------------------------------------
    assign dataLine = hostDataOe ? hostData : (devDataOe ? devData : IDLE_LINE);

    modport host (
        output accessStb,
        output regSel,
        output readNotWrite,
        output hostData,
        output hostDataOe,
        input dataLine
    );

    modport device (
        input accessStb,
        input regSel,
        input readNotWrite,
        output devData,
        output devDataOe,
        input dataLine
    );
endinterface

// ===== core/lcd_host_end.sv
// microprocessor end: polls busy before all but status reads, then moves each byte as one or two accesses
// assumes the display end answers a read in the cycle after the strobe
`timescale 1ns/1ps
module lcd_host_end
    import lcd_port_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // port to the display
    lcd_port_if.host port,
    // user requests
    input wire logic reqValid,
    input wire logic reqIsData,
    input wire logic reqRead,
    input wire logic [DATA_W-1:0] reqByte,
    output logic reqReady,
    // user answers
    output logic respValid,
    output logic [DATA_W-1:0] respByte,
    output logic hostFourBit
);

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_POLL = 3'b001,
        H_PWAIT = 3'b010,
        H_SEND = 3'b011,
        H_SGAP = 3'b100,
        H_READ = 3'b101,
        H_RWAIT = 3'b110
    } hstate_t;

    hstate_t state_ff, nxt_state;
    logic nib_ff, nxt_nib;
    logic four_ff, nxt_four;
    logic isData_ff, nxt_isData;
    logic isRead_ff, nxt_isRead;
    logic [DATA_W-1:0] byte_ff, nxt_byte;
    logic [NIB_W-1:0] hold_ff, nxt_hold;
    logic stb_ff, nxt_stb;
    logic rs_ff, nxt_rs;
    logic rw_ff, nxt_rw;
    logic oe_ff, nxt_oe;
    logic [DATA_W-1:0] hData_ff, nxt_hData;
    logic ready_ff, nxt_ready;
    logic rv_ff, nxt_rv;
    logic [DATA_W-1:0] rb_ff, nxt_rb;

    wire [NIB_W-1:0] lineHi = port.dataLine[DATA_W-1:NIB_W];
    wire busyNow = four_ff ? hold_ff[NIB_W-1] : port.dataLine[BUSY_BIT];
    wire isFuncSet = !isData_ff && byte_ff[FUNC_SET_MSB:FUNC_SET_LSB] == FUNC_SET_CODE;
    wire [DATA_W-1:0] sendByte = !four_ff ? byte_ff :
        (nib_ff ? {byte_ff[NIB_W-1:0], NIB_ZERO} : {byte_ff[DATA_W-1:NIB_W], NIB_ZERO});

    always_comb begin
        nxt_state = state_ff;
        nxt_nib = nib_ff;
        nxt_four = four_ff;
        nxt_isData = isData_ff;
        nxt_isRead = isRead_ff;
        nxt_byte = byte_ff;
        nxt_hold = hold_ff;
        nxt_stb = 1'b0;
        nxt_rs = rs_ff;
        nxt_rw = rw_ff;
        nxt_oe = 1'b0;
        nxt_hData = hData_ff;
        nxt_ready = ready_ff;
        nxt_rv = 1'b0;
        nxt_rb = rb_ff;
        case (state_ff)
            H_IDLE: begin
                if (reqValid && ready_ff) begin
                    nxt_ready = 1'b0;
                    nxt_isData = reqIsData;
                    nxt_isRead = reqRead;
                    nxt_byte = reqByte;
                    nxt_nib = 1'b0;
                    // a status read is itself the poll, so it goes straight out
                    nxt_state = (reqRead && !reqIsData) ? H_READ : H_POLL;
                end
            end
            H_POLL: begin
                nxt_stb = 1'b1;
                nxt_rs = 1'b0;
                nxt_rw = 1'b1;
                nxt_state = H_PWAIT;
            end
            H_PWAIT: begin
                if (stb_ff) begin
                    // the answer reaches the lines one cycle after the strobe
                    nxt_state = H_PWAIT;
                end else if (four_ff && !nib_ff) begin
                    // busy is judged only after both halves of the status (see R4)
                    nxt_hold = lineHi;
                    nxt_nib = 1'b1;
                    nxt_state = H_POLL;
                end else begin
                    nxt_nib = 1'b0;
                    if (busyNow) begin
                        nxt_state = H_POLL; // see R7
                    end else begin
                        nxt_state = isRead_ff ? H_READ : H_SEND;
                    end
                end
            end
            H_SEND: begin
                nxt_stb = 1'b1;
                nxt_rs = isData_ff;
                nxt_rw = 1'b0;
                nxt_oe = 1'b1;
                nxt_hData = sendByte; // see R3
                nxt_state = H_SGAP;
            end
            H_SGAP: begin
                if (four_ff && !nib_ff) begin
                    nxt_nib = 1'b1; // see R2
                    nxt_state = H_SEND;
                end else begin
                    if (isFuncSet) begin
                        nxt_four = !byte_ff[WIDTH_SEL_BIT]; // see R1
                    end
                    nxt_nib = 1'b0;
                    nxt_ready = 1'b1;
                    nxt_state = H_IDLE;
                end
            end
            H_READ: begin
                nxt_stb = 1'b1;
                nxt_rs = isData_ff;
                nxt_rw = 1'b1;
                nxt_state = H_RWAIT;
            end
            H_RWAIT: begin
                if (stb_ff) begin
                    // sampling now would see the idle pull-ups, not the answer
                    nxt_state = H_RWAIT;
                end else if (four_ff && !nib_ff) begin
                    nxt_hold = lineHi;
                    nxt_nib = 1'b1;
                    nxt_state = H_READ;
                end else begin
                    nxt_rb = four_ff ? {hold_ff, lineHi} : port.dataLine;
                    nxt_rv = 1'b1;
                    nxt_nib = 1'b0;
                    nxt_ready = 1'b1;
                    nxt_state = H_IDLE;
                end
            end
            default: begin
                nxt_state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state_ff <= H_IDLE;
            nib_ff <= 1'b0;
            four_ff <= 1'b0;
            isData_ff <= 1'b0;
            isRead_ff <= 1'b0;
            byte_ff <= '0;
            hold_ff <= '0;
            stb_ff <= 1'b0;
            rs_ff <= 1'b0;
            rw_ff <= 1'b1;
            oe_ff <= 1'b0;
            hData_ff <= '0;
            ready_ff <= 1'b1;
            rv_ff <= 1'b0;
            rb_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            nib_ff <= nxt_nib;
            four_ff <= nxt_four;
            isData_ff <= nxt_isData;
            isRead_ff <= nxt_isRead;
            byte_ff <= nxt_byte;
            hold_ff <= nxt_hold;
            stb_ff <= nxt_stb;
            rs_ff <= nxt_rs;
            rw_ff <= nxt_rw;
            oe_ff <= nxt_oe;
            hData_ff <= nxt_hData;
            ready_ff <= nxt_ready;
            rv_ff <= nxt_rv;
            rb_ff <= nxt_rb;
        end
    end

    assign port.accessStb = stb_ff;
    assign port.regSel = rs_ff;
    assign port.readNotWrite = rw_ff;
    assign port.hostData = hData_ff;
    assign port.hostDataOe = oe_ff;
    assign reqReady = ready_ff;
    assign respValid = rv_ff;
    assign respByte = rb_ff;
    assign hostFourBit = four_ff;

endmodule

// ===== core/lcd_device_end.sv
// display end of the host port: byte assembly, status answers, frame timing
// assumes host accesses are single-cycle strobes at least two cycles apart
//
// Notes on behaviour
// (R1) byte moves in one access or two
// (R2) four-bit uses upper lines; two accesses
// (R3) first access upper nibble, second lower
// (R4) host polls busy only after both halves
// (R5) four-bit status read returns two nibbles
// (R6) 60 oscillator clocks per common, 18 commons
// (R7) busy one blocks next instruction
// (R8) eight-bit width after reset
// (R9) new four-bit width restarts upper phase
`timescale 1ns/1ps
module lcd_device_end
    import lcd_port_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // port from the host
    lcd_port_if.device port,
    // controller core status
    input wire logic busyIn,
    input wire logic [ADDR_W-1:0] addrPtrIn,
    input wire logic [DATA_W-1:0] readDataIn,
    // completed host transfers
    output logic wrValid,
    output logic wrIsData,
    output logic [DATA_W-1:0] wrByte,
    output logic rdDone,
    output logic fourBitMode,
    // display timing
    output logic oscTick,
    output logic [CNT_W-1:0] comClock,
    output logic [COM_W-1:0] comIndex,
    output logic frameStart
);

    // ------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------
    logic four_ff;
    logic lowPhase_ff;
    logic [NIB_W-1:0] hiNib_ff;
    logic [DATA_W-1:0] rdLatch_ff;
    logic [DATA_W-1:0] dData_ff;
    logic dOe_ff;
    logic wrValid_ff;
    logic wrIsData_ff;
    logic [DATA_W-1:0] wrByte_ff;
    logic rdDone_ff;

    wire writeAcc = port.accessStb && !port.readNotWrite;
    wire readAcc = port.accessStb && port.readNotWrite;
    wire [NIB_W-1:0] lineHi = port.dataLine[DATA_W-1:NIB_W];
    // lower lines are not looked at in four-bit mode (see R2)
    wire [DATA_W-1:0] fullByte = four_ff ? {hiNib_ff, lineHi} : port.dataLine;
    wire byteDone = !four_ff || lowPhase_ff; // see R1
    wire isFuncSet = !port.regSel
        && fullByte[FUNC_SET_MSB:FUNC_SET_LSB] == FUNC_SET_CODE;
    wire wrDone = writeAcc && byteDone;
    wire selFour = wrDone && isFuncSet && !fullByte[WIDTH_SEL_BIT];
    wire selEight = wrDone && isFuncSet && fullByte[WIDTH_SEL_BIT];
    wire newFour = selFour && !four_ff;
    // busy in bit 7, pointer below it (see R7)
    wire [DATA_W-1:0] statusByte = {busyIn, addrPtrIn};
    wire [DATA_W-1:0] srcByte = port.regSel ? readDataIn : statusByte;
    // the byte is captured on the upper access so both halves match (see R5)
    wire [DATA_W-1:0] answer = !four_ff ? srcByte :
        (lowPhase_ff ? {rdLatch_ff[NIB_W-1:0], NIB_ZERO}
                     : {srcByte[DATA_W-1:NIB_W], NIB_ZERO});

    // ------------------------------------------------------------------
    // width and nibble phase
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            four_ff <= 1'b0; // see R8
            lowPhase_ff <= 1'b0;
        end else begin
            if (selFour) begin
                four_ff <= 1'b1;
            end else if (selEight) begin
                four_ff <= 1'b0;
            end
            if (newFour || selEight) begin
                lowPhase_ff <= 1'b0; // see R9
            end else if (port.accessStb && four_ff) begin
                lowPhase_ff <= !lowPhase_ff; // see R3
            end
        end
    end

    // ------------------------------------------------------------------
    // write assembly and read answers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            hiNib_ff <= '0;
            rdLatch_ff <= '0;
            dData_ff <= '0;
            dOe_ff <= 1'b0;
            wrValid_ff <= 1'b0;
            wrIsData_ff <= 1'b0;
            wrByte_ff <= '0;
            rdDone_ff <= 1'b0;
        end else begin
            wrValid_ff <= wrDone;
            rdDone_ff <= readAcc && port.regSel && byteDone;
            dOe_ff <= readAcc;
            if (writeAcc && four_ff && !lowPhase_ff) begin
                hiNib_ff <= lineHi; // see R3
            end
            if (wrDone) begin
                wrIsData_ff <= port.regSel;
                wrByte_ff <= fullByte;
            end
            if (readAcc && four_ff && !lowPhase_ff) begin
                rdLatch_ff <= srcByte; // see R5
            end
            if (readAcc) begin
                dData_ff <= answer;
            end
        end
    end

    // ------------------------------------------------------------------
    // frame timing from the divided oscillator
    // ------------------------------------------------------------------
    // the oscillator is modelled as an enable from ref_clk, so its rate is
    // exact here rather than the loose spread of a real rc oscillator
    logic [DIV_W-1:0] div_ff;
    logic tick_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [COM_W-1:0] com_ff;
    logic frame_ff;

    wire divWrap = div_ff == DIV_LAST;
    wire cntWrap = cnt_ff == CNT_LAST;
    wire comWrap = com_ff == COM_LAST;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
            cnt_ff <= '0;
            com_ff <= '0;
            frame_ff <= 1'b0;
        end else begin
            div_ff <= divWrap ? '0 : div_ff + 1'b1;
            tick_ff <= divWrap;
            frame_ff <= tick_ff && cntWrap && comWrap;
            if (tick_ff) begin
                cnt_ff <= cntWrap ? '0 : cnt_ff + 1'b1; // see R6
                if (cntWrap) begin
                    com_ff <= comWrap ? '0 : com_ff + 1'b1; // see R6
                end
            end
        end
    end

    assign port.devData = dData_ff;
    assign port.devDataOe = dOe_ff;
    assign wrValid = wrValid_ff;
    assign wrIsData = wrIsData_ff;
    assign wrByte = wrByte_ff;
    assign rdDone = rdDone_ff;
    assign fourBitMode = four_ff;
    assign oscTick = tick_ff;
    assign comClock = cnt_ff;
    assign comIndex = com_ff;
    assign frameStart = frame_ff;

endmodule

// ===== test/lcd_port_monitor.sv
// checker for the host port wire and the display end's timing outputs
// assumes one clock; tb_top instantiates it beside the port interface
`timescale 1ns/1ps
module lcd_port_monitor
    import lcd_port_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // port wire
    input wire logic accessStb,
    input wire logic readNotWrite,
    input wire logic [DATA_W-1:0] hostData,
    input wire logic hostDataOe,
    input wire logic devDataOe,
    input wire logic [DATA_W-1:0] dataLine,
    // end status
    input wire logic hostFourBit,
    input wire logic fourBitMode,
    input wire logic wrValid,
    input wire logic [DATA_W-1:0] wrByte,
    input wire logic oscTick,
    input wire logic [CNT_W-1:0] comClock,
    input wire logic [COM_W-1:0] comIndex,
    input wire logic frameStart
);
    // ------------------------------------------------------------------
    // helpers: last two written nibbles, cycles since the last tick
    // ------------------------------------------------------------------
    logic [NIB_W-1:0] lastNib_ff;
    logic [NIB_W-1:0] prevNib_ff;
    logic [DIV_W-1:0] divCnt_ff;
    logic tickSeen_ff;
    wire wrAccess = accessStb && !readNotWrite;

    always_ff @(posedge ref_clk) begin
        if (wrAccess) begin
            prevNib_ff <= lastNib_ff;
            lastNib_ff <= dataLine[7:4];
        end
    end

    // the first tick after reset is not measured: its phase is a design choice
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            divCnt_ff <= '0;
            tickSeen_ff <= 1'b0;
        end else begin
            divCnt_ff <= oscTick ? '0 : divCnt_ff + 1'b1;
            tickSeen_ff <= tickSeen_ff | oscTick;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    stb_spacing_a: assert property (accessStb |=> !accessStb)
        else $error("access strobes closer than two cycles");
    read_answer_a: assert property (accessStb && readNotWrite |=> devDataOe && !hostDataOe)
        else $error("read strobe not answered in the next cycle");
    answer_cause_a: assert property (devDataOe |-> $past(accessStb && readNotWrite))
        else $error("device drove the lines without a read");
    byte_write_a: assert property (wrAccess && !fourBitMode |=> wrValid && wrByte == $past(dataLine))
        else $error("eight-bit write not taken as a whole byte");
    nibble_order_a: assert property (wrValid && $past(fourBitMode) |-> wrByte == {prevNib_ff, lastNib_ff})
        else $error("four-bit byte not upper nibble first");
    low_lines_a: assert property (hostDataOe && hostFourBit |-> hostData[3:0] == NIB_ZERO)
        else $error("host drove low lines in four-bit width");
    write_cause_a: assert property (wrValid |-> $past(wrAccess))
        else $error("write completed without a write access");
    width_reset_a: assert property ($rose(resetn) |-> !fourBitMode && !hostFourBit)
        else $error("width not eight-bit after reset");
    tick_period_a: assert property (oscTick && tickSeen_ff |-> divCnt_ff == DIV_LAST)
        else $error("oscillator tick spacing wrong");
    com_bound_a: assert property (comClock <= CNT_LAST && comIndex <= COM_LAST)
        else $error("common counters out of range");
    com_step_a: assert property ($changed(comIndex) |-> comClock == '0)
        else $error("common index moved without a phase wrap");
    frame_mark_a: assert property (frameStart |-> comClock == '0 && comIndex == '0)
        else $error("frame start away from phase zero");

    cover property (wrValid && fourBitMode);
    cover property (devDataOe && hostFourBit);
    cover property (oscTick && tickSeen_ff);
endmodule

// ===== test/tb_top.sv
// self-checking bench: host end and display end joined by the port interface
// assumes a 100 MHz clock; user side of both ends driven at falling edges
`timescale 1ns/1ps
module tb_top;
    import lcd_port_pkg::*;
    logic ref_clk, resetn, reqValid, reqIsData, reqRead, reqReady, respValid, hostFourBit;
    logic [7:0] reqByte, respByte, readDataIn, wrByte;
    logic busyIn, wrValid, wrIsData, rdDone, fourBitMode, oscTick, frameStart;
    logic [ADDR_W-1:0] addrPtrIn;
    logic [CNT_W-1:0] comClock;
    logic [COM_W-1:0] comIndex;
    logic [8:0] wrQ[$];
    logic [7:0] rdQ[$];
    int fails, compares, cycles, wrSeen, n, rdSeen, rdWant;
    logic [CNT_W-1:0] c0;

    lcd_port_if lcd_port_if_inst();
    lcd_host_end lcd_host_end_inst(.ref_clk(ref_clk), .resetn(resetn), .port(lcd_port_if_inst),
        .reqValid(reqValid), .reqIsData(reqIsData), .reqRead(reqRead), .reqByte(reqByte),
        .reqReady(reqReady), .respValid(respValid), .respByte(respByte),
        .hostFourBit(hostFourBit));
    lcd_device_end lcd_device_end_inst(.ref_clk(ref_clk), .resetn(resetn),
        .port(lcd_port_if_inst), .busyIn(busyIn), .addrPtrIn(addrPtrIn),
        .readDataIn(readDataIn), .wrValid(wrValid), .wrIsData(wrIsData), .wrByte(wrByte),
        .rdDone(rdDone), .fourBitMode(fourBitMode), .oscTick(oscTick), .comClock(comClock),
        .comIndex(comIndex), .frameStart(frameStart));
    lcd_port_monitor lcd_port_monitor_inst(.ref_clk(ref_clk), .resetn(resetn),
        .accessStb(lcd_port_if_inst.accessStb), .readNotWrite(lcd_port_if_inst.readNotWrite),
        .hostData(lcd_port_if_inst.hostData), .hostDataOe(lcd_port_if_inst.hostDataOe),
        .devDataOe(lcd_port_if_inst.devDataOe), .dataLine(lcd_port_if_inst.dataLine),
        .hostFourBit(hostFourBit), .fourBitMode(fourBitMode), .wrValid(wrValid),
        .wrByte(wrByte), .oscTick(oscTick), .comClock(comClock), .comIndex(comIndex),
        .frameStart(frameStart));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // compare, report and request tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report;
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one request at a time; the host has no queue
    task automatic req(input logic isData, input logic rd, input logic [7:0] b);
        while (reqReady !== 1'b1) @(negedge ref_clk);
        reqValid = 1'b1;
        reqIsData = isData;
        reqRead = rd;
        reqByte = b;
        @(negedge ref_clk);
        reqValid = 1'b0;
        @(negedge ref_clk);
        while (reqReady !== 1'b1) @(negedge ref_clk);
    endtask

    task automatic wrExp(input logic isData, input logic [7:0] b);
        wrQ.push_back({isData, b});
        req(isData, 1'b0, b);
    endtask

    // instruction bytes keep bit 7 set so none of them is a width select
    task automatic mix(input int k);
        repeat (k) begin
            wrExp(1'b1, 8'($urandom));
            wrExp(1'b0, 8'($urandom) | 8'h80);
            busyIn = 1'($urandom);
            addrPtrIn = 7'($urandom);
            rdQ.push_back({busyIn, addrPtrIn});
            req(1'b0, 1'b1, 8'h00);
            busyIn = 1'b0;
            readDataIn = 8'($urandom);
            rdQ.push_back(readDataIn);
            rdWant++;
            req(1'b1, 1'b1, 8'h00);
        end
    endtask

    // ------------------------------------------------------------------
    // result watchers and timeout
    // ------------------------------------------------------------------
    always @(negedge ref_clk) begin
        if (resetn && wrValid === 1'b1) begin
            wrSeen++;
            check("written byte", wrQ.size() > 0 ? wrQ.pop_front() : 'x, {wrIsData, wrByte});
        end
        if (resetn && respValid === 1'b1) begin
            check("read byte", rdQ.size() > 0 ? rdQ.pop_front() : 'x, respByte);
        end
        if (resetn && rdDone === 1'b1) begin
            rdSeen++;
        end
        if (lcd_port_if_inst.hostDataOe === 1'b1 && hostFourBit === 1'b1) begin
            check("low data lines", 16'h0, lcd_port_if_inst.dataLine[3:0]);
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        resetn = 1'b0;
        reqValid = 1'b0;
        reqIsData = 1'b0;
        reqRead = 1'b0;
        reqByte = 8'h00;
        busyIn = 1'b0;
        addrPtrIn = '0;
        readDataIn = 8'h00;
        void'($urandom(34));
        repeat (4) @(negedge ref_clk);
        resetn = 1'b1;
        check("width after reset", 16'h0, {hostFourBit, fourBitMode});
        mix(4);
        wrExp(1'b0, 8'h20);
        check("four-bit selected", 16'h3, {hostFourBit, fourBitMode});
        mix(4);
        busyIn = 1'b1;
        n = wrSeen;
        fork
            wrExp(1'b1, 8'hA5);
            begin
                repeat (40) @(negedge ref_clk);
                check("write held while busy", 16'(n), 16'(wrSeen));
                busyIn = 1'b0;
            end
        join
        wrExp(1'b0, 8'h20);
        mix(1);
        wrExp(1'b0, 8'h30);
        check("eight-bit selected", 16'h0, {hostFourBit, fourBitMode});
        mix(1);
        wrExp(1'b0, 8'h20);
        mix(1);
        while (oscTick !== 1'b1) @(negedge ref_clk);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (oscTick !== 1'b1);
        check("tick spacing", 16'(OSC_DIV), 16'(n));
        repeat (5) @(negedge ref_clk);
        c0 = comClock;
        repeat (OSC_DIV) @(negedge ref_clk);
        check("common step", 16'((c0 + 1) % CLKS_PER_COM), 16'(comClock));
        check("pending results", 16'h0, 16'(wrQ.size() + rdQ.size()));
        check("data reads done", 16'(rdWant), 16'(rdSeen));
        final_report();
    end
endmodule
